// ### logic/rco_refclk.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - four independent generators, each with control and trim registers
// - output is source over twice the divider; zero bypasses a sampled source, halves the own clock
// - generator runs only while its enable bit is set
// - stop-in-idle bit halts the generator during Idle
// - pin is driven only while output pin enable is set
// - run-in-sleep keeps output in Sleep; ignored for system/peripheral clock
// - switch-pending bit reads one until divider change completes
// - request status bit shows the clock request is active
// - four-bit select picks one of twelve sources; top four reserved
// - system or peripheral source follows that clock's own switching
// - trim adds value over 512 to the half period
module rco_refclk (
	input  wire logic                       REF_CLK_IN,            // 20 MHz system clock
	input  wire logic                       ARST_N_IN,             // async reset
	input  wire logic [rco_pkg::ADDR_W-1:0] ADDR_IN,               // register address
	input  wire logic [31:0]                WDATA_IN,              // write data
	input  wire logic                       WR_IN,                 // write strobe
	input  wire logic                       RD_IN,                 // read strobe
	output logic      [31:0]                RDATA_OUT,             // read data, next cycle
	input  wire logic                       IDLE_IN,               // device in Idle
	input  wire logic                       SLEEP_IN,              // device in Sleep
	input  wire logic                       PB_CLK_IN,             // peripheral clock
	input  wire logic                       PRIMARY_OSCILLATOR_IN, // primary oscillator
	input  wire logic                       FAST_RC_OSCILLATOR_IN, // fast rc
	input  wire logic                       LOW_POWER_RC_IN,       // low-power rc
	input  wire logic                       SECONDARY_OSC_IN,      // secondary oscillator
	input  wire logic                       USB_PLL_IN,            // usb pll
	input  wire logic                       SYS_PLL_IN,            // system pll
	input  wire logic                       ETH_PLL_IN,            // ethernet pll output
	input  wire logic                       WIRELESS_PLL_IN,       // wireless pll output
	input  wire logic                       BT_PLL_A_IN,           // bt pll
	input  wire logic                       REF_CLOCK_IN_PIN_IN,   // reference input pin
	output logic      [3:0]                 REF_CLOCK_OUT_PIN_OUT, // output pins
	output logic      [3:0]                 REF_CLOCK_OUT_PIN_OE_OUT // pin drive enables
);
	import rco_pkg::*;

	typedef struct packed {
		logic [NSRC-2:0]                     s1;
		logic [NSRC-2:0]                     s2;
		logic [NSRC-2:0]                     s3;
		logic                                sys_tgl;
		logic [RCO_NUM-1:0][DIV_W-1:0]       div;
		logic [RCO_NUM-1:0][TRIM_W-1:0]      trim;
		logic [RCO_NUM-1:0][SEL_W-1:0]       sel;
		logic [RCO_NUM-1:0]                  on;
		logic [RCO_NUM-1:0]                  stop_in_idle;
		logic [RCO_NUM-1:0]                  oe;
		logic [RCO_NUM-1:0]                  run_in_sleep;
		logic [RCO_NUM-1:0]                  pend;
		logic [RCO_NUM-1:0]                  active;
		logic [RCO_NUM-1:0]                  pin;
		logic [RCO_NUM-1:0]                  pin_en;
		logic [31:0]                         rdata;
	} rco_state_t;

	rco_state_t r, n;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// {hit, is_trim, channel}
	function automatic logic [3:0] rco_decode(input logic [ADDR_W-1:0] a);
		logic hit;
		hit = (a[7:6] == 2'b00) && ((a[3:0] == CTRL_OFF) || (a[3:0] == TRIM_OFF));
		return {hit, a[3:0] == TRIM_OFF, a[5:4]};
	endfunction : rco_decode

	function automatic logic rco_pick(input logic [NSRC-1:0] v, input logic [SEL_W-1:0] s);
		logic res;
		res = 1'b0;
		if (s <= SEL_PIN) begin
			res = v[s];
		end
		return res;
	endfunction : rco_pick

	// ----------------------------------------
	// source sampling
	// ----------------------------------------
	logic [NSRC-2:0]    raw_src;
	logic [NSRC-1:0]    tick_v;
	logic [NSRC-1:0]    lvl_v;
	logic [RCO_NUM-1:0] run;
	logic [RCO_NUM-1:0] src_tick;
	logic [RCO_NUM-1:0] src_lvl;
	logic [RCO_NUM-1:0] gen_clk;
	logic [RCO_NUM-1:0] gen_done;
	logic [3:0]         wdec;
	logic [3:0]         rdec;

	// index plus one equals select code; code 0 is this block's own clock, which tick_v and lvl_v add at bit 0
	assign raw_src = {REF_CLOCK_IN_PIN_IN, BT_PLL_A_IN, WIRELESS_PLL_IN, ETH_PLL_IN,
		SYS_PLL_IN, USB_PLL_IN, SECONDARY_OSC_IN, LOW_POWER_RC_IN,
		FAST_RC_OSCILLATOR_IN, PRIMARY_OSCILLATOR_IN, PB_CLK_IN};
	// sampled sources see rising edges only; sources above 10 MHz alias
	assign tick_v = {r.s2 & ~r.s3, 1'b1};
	// bypass of the own clock can only reach half rate from a flip-flop
	assign lvl_v = {r.s2, r.sys_tgl};
	assign wdec = rco_decode(ADDR_IN);
	assign rdec = rco_decode(ADDR_IN);

	// ----------------------------------------
	// generators
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < RCO_NUM; g++) begin : gen_ch
			assign src_tick[g] = rco_pick(tick_v, r.sel[g]);
			assign src_lvl[g] = rco_pick(lvl_v, r.sel[g]);
			assign run[g] = r.on[g] && !(r.stop_in_idle[g] && IDLE_IN)
				&& !(SLEEP_IN && !(r.run_in_sleep[g] && r.sel[g] > SEL_PB));
			rco_half_div u_div (
				.clk_in      (REF_CLK_IN),
				.rst_n_in    (ARST_N_IN),
				.run_in      (run[g]),
				.src_tick_in (src_tick[g]),
				.src_lvl_in  (src_lvl[g]),
				.load_in     (r.pend[g]),
				.div_in      (r.div[g]),
				.trim_in     (r.trim[g]),
				.clk_out     (gen_clk[g]),
				.done_out    (gen_done[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// registers and next state
	// ----------------------------------------
	always_comb begin
		n = r;
		n.s1 = raw_src;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.sys_tgl = ~r.sys_tgl;
		n.rdata = 32'h0000_0000;
		for (int i = 0; i < RCO_NUM; i++) begin
			n.active[i] = r.on[i] | (r.active[i] & gen_clk[i]);
			n.pin[i] = r.oe[i] & gen_clk[i];
			n.pin_en[i] = r.oe[i] & r.on[i];
			if (gen_done[i]) begin
				n.pend[i] = 1'b0;
			end
		end
		if (WR_IN && wdec[3]) begin
			if (wdec[2]) begin
				n.trim[wdec[1:0]] = WDATA_IN[TRIM_LSB +: TRIM_W];
				n.pend[wdec[1:0]] = 1'b1;
			end else begin
				n.div[wdec[1:0]] = WDATA_IN[DIV_LSB +: DIV_W];
				n.on[wdec[1:0]] = WDATA_IN[BIT_ON];
				n.stop_in_idle[wdec[1:0]] = WDATA_IN[BIT_STOP_IN_IDLE];
				n.oe[wdec[1:0]] = WDATA_IN[BIT_OE];
				n.run_in_sleep[wdec[1:0]] = WDATA_IN[BIT_RUN_IN_SLEEP];
				n.sel[wdec[1:0]] = WDATA_IN[SEL_W-1:0];
				// set beats a same-cycle completion
				if (WDATA_IN[BIT_PEND] || WDATA_IN[DIV_LSB +: DIV_W] != r.div[wdec[1:0]]) begin
					n.pend[wdec[1:0]] = 1'b1;
				end
			end
		end
		if (RD_IN && rdec[3]) begin
			if (rdec[2]) begin
				n.rdata = {r.trim[rdec[1:0]], 23'h000000};
			end else begin
				n.rdata = {1'b0, r.div[rdec[1:0]], r.on[rdec[1:0]], 1'b0, r.stop_in_idle[rdec[1:0]],
					r.oe[rdec[1:0]], r.run_in_sleep[rdec[1:0]], 1'b0, r.pend[rdec[1:0]],
					r.active[rdec[1:0]], 4'h0, r.sel[rdec[1:0]]};
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign RDATA_OUT = r.rdata;
	assign REF_CLOCK_OUT_PIN_OUT = r.pin;
	assign REF_CLOCK_OUT_PIN_OE_OUT = r.pin_en;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_off_is_silent: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		(!r.on[0]) [*3] |-> !r.pin[0] && !r.pin_en[0])
		else $error("disabled generator still drives pin");

	a_pin_gated_oe: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		!r.oe[1] ##1 !r.oe[1] |-> !REF_CLOCK_OUT_PIN_OUT[1] && !REF_CLOCK_OUT_PIN_OE_OUT[1])
		else $error("pin active without output enable");

	a_idle_stops: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		(r.stop_in_idle[0] && IDLE_IN) [*3] |-> !r.pin[0])
		else $error("generator runs in idle with stop-in-idle");

	a_sleep_sysclk: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		(SLEEP_IN && r.sel[0] <= SEL_PB) [*3] |-> !r.pin[0])
		else $error("system source clock runs in sleep");

	a_pend_clears: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		$fell(r.pend[0]) |-> $past(gen_done[0]))
		else $error("switch pending cleared without completion");

	a_active_follows: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		$rose(r.on[2]) |=> r.active[2] ##1 (RD_IN || r.active[2]))
		else $error("request status not set after enable");

	a_half_period: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		(run[0] && r.sel[0] == SEL_SYS && r.div[0] == 15'd2 && r.trim[0] == 9'd0 && !r.pend[0]) [*6]
		|-> (gen_clk[0] != $past(gen_clk[0], 2)) && (gen_clk[0] == $past(gen_clk[0], 4)))
		else $error("divider half period wrong");

	a_unmapped_zero: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		RD_IN && !rdec[3] |=> RDATA_OUT == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_load_at_edge: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
		gen_done[0] && $past(run[0]) && $past(gen_ch[0].u_div.r.div) != 15'd0
		|-> gen_clk[0] != $past(gen_clk[0]))
		else $error("divider switched off a half-period boundary");
endmodule : rco_refclk
`default_nettype wire

// ### logic/rco_pkg.sv
`default_nettype none
package rco_pkg;
	// ----------------------------------------
	// map and layout
	// ----------------------------------------
	localparam int        RCO_NUM    = 4;
	localparam int        ADDR_W     = 8;
	localparam logic [3:0] CTRL_OFF  = 4'h0;
	localparam logic [3:0] TRIM_OFF  = 4'h4;
	localparam int        DIV_W      = 15;
	localparam int        TRIM_W     = 9;
	localparam int        SEL_W      = 4;
	localparam int        NSRC       = 12;
	localparam int        DIV_LSB    = 16;
	localparam int        BIT_ON     = 15;
	localparam int        BIT_STOP_IN_IDLE   = 13;
	localparam int        BIT_OE     = 12;
	localparam int        BIT_RUN_IN_SLEEP   = 11;
	localparam int        BIT_PEND   = 9;
	localparam int        BIT_ACT    = 8;
	localparam int        TRIM_LSB   = 23;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] TRIM_RST = 32'h0000_0000;
	// ----------------------------------------
	// source select codes
	// ----------------------------------------
	localparam logic [3:0] SEL_SYS   = 4'h0;
	localparam logic [3:0] SEL_PB    = 4'h1;
	localparam logic [3:0] SEL_PIN   = 4'hB;
endpackage : rco_pkg
`default_nettype wire

// ### logic/rco_half_div.sv
`timescale 1ns/1ns
`default_nettype none
module rco_half_div (
	input  wire logic                        clk_in,      // block clock
	input  wire logic                        rst_n_in,    // async reset
	input  wire logic                        run_in,      // generator allowed to run
	input  wire logic                        src_tick_in, // one source period elapsed
	input  wire logic                        src_lvl_in,  // source level for bypass
	input  wire logic                        load_in,     // new divider values waiting
	input  wire logic [rco_pkg::DIV_W-1:0]   div_in,      // requested half period
	input  wire logic [rco_pkg::TRIM_W-1:0]  trim_in,     // requested fraction
	output logic                             clk_out,     // generated clock
	output logic                             done_out     // switch completed pulse
);
	import rco_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0]  cnt;
		logic [DIV_W-1:0]  div;
		logic [TRIM_W-1:0] trim;
		logic [TRIM_W-1:0] acc;
		logic              extra;
		logic              lvl;
		logic              done;
	} rco_div_t;

	rco_div_t r, n;
	logic [TRIM_W:0] sum;

	always_comb begin
		n = r;
		n.done = 1'b0;
		sum = {1'b0, r.acc} + {1'b0, r.trim};
		if (!run_in) begin
			n.lvl = 1'b0;
			n.cnt = '0;
			n.extra = 1'b0;
			if (load_in) begin
				n.div = div_in;
				n.trim = trim_in;
				n.done = 1'b1;
			end
		end else if (r.div == '0) begin
			n.lvl = src_lvl_in;
			if (src_tick_in && load_in) begin
				n.div = div_in;
				n.trim = trim_in;
				n.done = 1'b1;
			end
		end else if (src_tick_in) begin
			if ({1'b0, r.cnt} + 16'd1 >= {1'b0, r.div} + {15'd0, r.extra}) begin
				// half-period boundary: while dividing, only here may values change
				n.cnt = '0;
				n.lvl = ~r.lvl;
				n.acc = sum[TRIM_W-1:0];
				n.extra = sum[TRIM_W];
				if (load_in) begin
					n.div = div_in;
					n.trim = trim_in;
					n.done = 1'b1;
				end
			end else begin
				n.cnt = r.cnt + 15'd1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign clk_out = r.lvl;
	assign done_out = r.done;
endmodule : rco_half_div
`default_nettype wire

// ### test/rco_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// free-running source oscillators
// ----------------------------------------
// half periods of 130 ns and up keep every source below 5 MHz,
// well inside what the synchronisers can sample at 20 MHz
module rco_src_model (
	output logic [10:0] src_out // source clocks, codes 1..11
);
	for (genvar i = 0; i < 11; i++) begin : g_src
		initial begin
			src_out[i] = 1'b0;
			#(7 * i + 3);
			forever #(130 + 30 * i) src_out[i] = ~src_out[i];
		end
	end
endmodule : rco_src_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import rco_pkg::*;
	logic              clk, rst_n, wr_s, rd_s, idle, sleep;
	logic [ADDR_W-1:0] addr;
	logic [31:0]       wdata, d;
	wire logic [31:0]  rdata;
	wire logic [10:0]  src;
	wire logic [3:0]   pin, pin_oe;
	int                errors, checked, cyc, c;
	rco_src_model u_src (.src_out(src));
	rco_refclk dut (.REF_CLK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .IDLE_IN(idle), .SLEEP_IN(sleep),
		.PB_CLK_IN(src[0]), .PRIMARY_OSCILLATOR_IN(src[1]), .FAST_RC_OSCILLATOR_IN(src[2]),
		.LOW_POWER_RC_IN(src[3]), .SECONDARY_OSC_IN(src[4]), .USB_PLL_IN(src[5]),
		.SYS_PLL_IN(src[6]), .ETH_PLL_IN(src[7]), .WIRELESS_PLL_IN(src[8]),
		.BT_PLL_A_IN(src[9]), .REF_CLOCK_IN_PIN_IN(src[10]),
		.REF_CLOCK_OUT_PIN_OUT(pin), .REF_CLOCK_OUT_PIN_OE_OUT(pin_oe));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ----------------------------------------
	// bus tasks and compares
	// ----------------------------------------
	task automatic conclude;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cnt(input int got, input int exp);
		checked++;
		if (got != exp) begin
			errors++;
			$display("Error at %0t: count %h expected %h", $time, got, exp);
		end
	endtask : cnt
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : rd
	function automatic logic [7:0] ra(input int ch, input logic [3:0] off);
		ra = 8'(16 * ch) | {4'h0, off};
	endfunction : ra
	function automatic logic [31:0] mk(input int dv, input logic si, oe, rs, input logic [3:0] s);
		mk = 32'(dv) << DIV_LSB;
		mk[BIT_ON]   = 1'b1;
		mk[BIT_STOP_IN_IDLE] = si;
		mk[BIT_OE]   = oe;
		mk[BIT_RUN_IN_SLEEP] = rs;
		mk[3:0]      = s;
	endfunction : mk
	// software disables first and waits for the request to drop, so that
	// select, control and trim are never written while the request is live
	task automatic cfg(input int ch, input logic [31:0] ct, input logic [31:0] tr);
		wr(ra(ch, CTRL_OFF), 32'h0000_0000);
		d = 32'hFFFF_FFFF;
		for (int i = 0; i < 50 && d[BIT_ACT] !== 1'b0; i++) rd(ra(ch, CTRL_OFF), d);
		wr(ra(ch, TRIM_OFF), tr);
		wr(ra(ch, CTRL_OFF), ct);
	endtask : cfg
	task automatic tog(input int ch, input int n, output int k);
		logic p;
		k = 0;
		repeat (4) @(negedge clk);
		p = pin[ch];
		repeat (n) begin
			@(negedge clk);
			if (pin[ch] !== p) k++;
			p = pin[ch];
		end
	endtask : tog
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rst_n, wr_s, rd_s, idle, sleep} = '0;
		{addr, wdata} = '0;
		{errors, checked, cyc} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int ch = 0; ch < RCO_NUM; ch++) begin
			rd(ra(ch, CTRL_OFF), d);
			chk(d, CTRL_RST);
			rd(ra(ch, TRIM_OFF), d);
			chk(d, TRIM_RST);
		end
		wr(8'h08, 32'hFFFF_FFFF);
		rd(8'h08, d);
		chk(d, 32'h0000_0000);
		wr(ra(2, CTRL_OFF), 32'h0000_0100);
		rd(ra(2, CTRL_OFF), d);
		chk(d, 32'h0000_0000);
		cfg(0, mk(2, 0, 1, 0, SEL_SYS), 0);
		tog(0, 40, c);
		cnt(c, 20);
		rd(ra(0, CTRL_OFF), d);
		chk(d, mk(2, 0, 1, 0, SEL_SYS) | 32'h0000_0100);
		cfg(1, mk(0, 0, 0, 0, SEL_SYS), 0);
		tog(1, 40, c);
		cnt(c, 0);
		chk({28'h0, pin_oe}, 32'h0000_0001);
		cfg(1, mk(0, 0, 1, 0, SEL_SYS), 0);
		tog(1, 40, c);
		cnt(c, 40);
		cfg(0, mk(1, 0, 1, 0, SEL_SYS), 32'(256) << TRIM_LSB);
		tog(0, 48, c);
		cnt(c, 32);
		cfg(0, mk(20, 0, 1, 0, SEL_SYS), 0);
		tog(0, 1, c);
		@(pin[0]);
		wr(ra(0, TRIM_OFF), 32'h0000_0000);
		rd(ra(0, CTRL_OFF), d);
		chk({31'h0, d[BIT_PEND]}, 32'h1);
		for (int i = 0; i < 30 && d[BIT_PEND] !== 1'b0; i++) rd(ra(0, CTRL_OFF), d);
		chk({31'h0, d[BIT_PEND]}, 32'h0);
		tog(0, 80, c);
		cnt(c, 4);
		cfg(0, mk(2, 1, 1, 0, SEL_SYS), 0);
		idle <= 1'b1;
		tog(0, 40, c);
		cnt(c, 0);
		chk({31'h0, pin[0]}, 32'h0);
		tog(1, 40, c);
		cnt(c, 40);
		@(posedge clk);
		idle <= 1'b0;
		tog(0, 40, c);
		cnt(c, 20);
		cfg(0, mk(0, 0, 1, 1, SEL_SYS), 0);
		sleep <= 1'b1;
		tog(0, 40, c);
		cnt(c, 0);
		cfg(0, mk(0, 0, 1, 1, 4'h2), 0);
		tog(0, 60, c);
		cnt(int'(c > 0), 1);
		cfg(0, mk(0, 0, 1, 0, 4'h2), 0);
		tog(0, 60, c);
		cnt(c, 0);
		@(posedge clk);
		sleep <= 1'b0;
		for (int s = 1; s < 13; s++) begin
			cfg(2, mk(0, 0, 1, 0, 4'(s)), 0);
			tog(2, 60, c);
			cnt(int'(c > 0), int'(s <= SEL_PIN));
		end
		conclude();
	end
endmodule : tb
`default_nettype wire
